// [bldc_commutation_direction_ctrl.sv]
// Commutation, direction reversal, chopping and protection logic of a brushless motor controller.
`timescale 1ns/10ps
`default_nettype none
`include "bldc_defines.svh"
// Notes on behaviour
// - Direction request goes through a latch, then a two-stage shift register.
// - Direction latch follows only while speed is below threshold; otherwise holds.
// - Latch or shift register input differing from output forces all drives off, except in brake.
// - Shift register advances on oscillator tick; change lands in one to two periods.
// - A toggle of direction request fires one tach pulse when no tach pulse is already running.
// - Decoder derives six drives from position latches and effective direction.
// - PWM comparator clears PWM latch, chopping drives until next oscillator cycle.
// - Peak current ends present on-time, giving current-limit operation.
// - Over-current sets soft start; outside brake drives stay off until it clears, in brake only while over-current lasts.
// - Overvoltage or coast input shuts all drives off.
// - Position change loads latches and, outside brake, starts a tach pulse.
// - Position latches ignore inputs while tach pulse is high.
// - Quad select low chops low side only; high chops all; brake ignores it.
// - Brake: high sides off, low sides on, no commutation tach, still protected and chopped.
module bldc_commutation_direction_ctrl
	import bldc_pkg::*;
#(
	parameter int OSC_CYCLES  = `OSC_CYCLES,
	parameter int TACH_CYCLES = `TACH_CYCLES
) (
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        rst,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Sensor, command and comparator inputs.
	input  wire logic        rotor_sensor_a,
	input  wire logic        rotor_sensor_b,
	input  wire logic        rotor_sensor_c,
	input  wire logic        dir_request,
	input  wire logic        speed_below_threshold,
	input  wire logic        pwm_comparator_flag,
	input  wire logic        peak_current_flag,
	input  wire logic        over_current_flag,
	input  wire logic        overvoltage_coast_input,
	input  wire logic        brake_timing_input,
	input  wire logic        quad_select,
	input  wire logic        undervoltage_flag,
	input  wire logic        soft_start_discharged,
	// Drives and indicators.
	output logic      [2:0]  high_side_drives_n,
	output logic      [2:0]  low_side_drives,
	output logic             tach_pulse,
	output logic             soft_start_node,
	output logic             irq
);
	logic [`SYNC_WIDTH-1:0] raw_in;
	logic [`SYNC_WIDTH-1:0] sync_in;
	phase_t pos_s;
	logic dir_s, speed_low_s, pwm_cmp_s, peak_s, oc_s, ov_s, brake_s, quad_s, uv_s, ss_empty_s;

	assign raw_in = {soft_start_discharged, undervoltage_flag, quad_select, brake_timing_input,
		overvoltage_coast_input, over_current_flag, peak_current_flag, pwm_comparator_flag,
		speed_below_threshold, dir_request, rotor_sensor_a, rotor_sensor_b, rotor_sensor_c};

	bldc_sync #(.WIDTH(`SYNC_WIDTH)) u_sync (
		.clock (clock),
		.rst   (rst),
		.din   (raw_in),
		.dout  (sync_in)
	);

	assign {ss_empty_s, uv_s, quad_s, brake_s, ov_s, oc_s, peak_s, pwm_cmp_s, speed_low_s, dir_s, pos_s} = sync_in;

	// Six-step table; a reversed direction swaps high and low phases.
	// six-step table
	function automatic logic [5:0] decode(input phase_t pos, input logic rev);
		logic [5:0] hl;
		hl = 6'h00;
		case (pos)
			3'h5: hl = {3'b100, 3'b010};
			3'h4: hl = {3'b100, 3'b001};
			3'h6: hl = {3'b010, 3'b001};
			3'h2: hl = {3'b010, 3'b100};
			3'h3: hl = {3'b001, 3'b100};
			3'h1: hl = {3'b001, 3'b010};
			default: hl = 6'h00;
		endcase
		if (rev)
			hl = {hl[2:0], hl[5:3]};
		return hl;
	endfunction

	count_t osc_cnt_reg, osc_cnt_next, tach_cnt_reg, tach_cnt_next;
	logic osc_tick, pwm_latch_reg, pwm_latch_next;
	logic dir_latch_reg, dir_latch_next, dir_prev_reg, dir_prev_next;
	logic [1:0] dir_shift_reg, dir_shift_next;
	phase_t pos_reg, pos_next;
	logic tach_next, ss_next, dir_inhibit, pos_load, tach_fire, drives_off;
	logic [5:0] dec;
	logic [2:0] hi_on, lo_on;
	logic [2:0] high_n_next, low_next;
	logic enable;

	// Oscillator tick ends each PWM period.
	assign osc_tick = (osc_cnt_reg == count_t'(OSC_CYCLES - 1));

	assign dir_inhibit = (dir_s != dir_latch_reg) || (dir_latch_reg != dir_shift_reg[1]);
	assign pos_load  = (pos_s != pos_reg) && !tach_pulse;
	assign tach_fire = (pos_load && !brake_s) || (dir_s != dir_prev_reg);
	assign drives_off = dir_inhibit || oc_s || ov_s || uv_s || soft_start_node || !enable;
	assign dec = decode(pos_reg, dir_shift_reg[1]);

	// Next values of the oscillator, latches, tach timer and soft start.
	always_comb
	begin
		osc_cnt_next = osc_tick ? 16'h0000 : osc_cnt_reg + 16'h0001;
		pwm_latch_next = osc_tick ? 1'b1 : pwm_latch_reg;
		if (pwm_cmp_s || peak_s)
			pwm_latch_next = 1'b0;
		dir_latch_next = speed_low_s ? dir_s : dir_latch_reg;
		dir_shift_next = osc_tick ? {dir_shift_reg[0], dir_latch_reg} : dir_shift_reg;
		dir_prev_next = dir_s;
		pos_next = pos_load ? pos_s : pos_reg;
		tach_cnt_next = tach_cnt_reg;
		tach_next = tach_pulse;
		if (tach_pulse)
		begin
			tach_cnt_next = tach_cnt_reg - 16'h0001;
			tach_next = (tach_cnt_reg != 16'h0000); // Ending at zero keeps the pulse TACH_CYCLES long.
		end
		else if (tach_fire)
		begin
			tach_cnt_next = count_t'(TACH_CYCLES - 1);
			tach_next = 1'b1;
		end
		if (oc_s || uv_s)
			ss_next = 1'b1;
		else
			ss_next = soft_start_node && !ss_empty_s;
	end

	// Drive composition.
	always_comb
	begin
		if (brake_s)
		begin
			hi_on = 3'b000;
			lo_on = {3{pwm_latch_reg && !peak_s && !oc_s && !ov_s && !uv_s && enable}};
		end
		else
		begin
			hi_on = dec[5:3] & {3{pwm_latch_reg || !quad_s}};
			lo_on = dec[2:0] & {3{pwm_latch_reg}};
			if (drives_off)
			begin
				hi_on = 3'b000;
				lo_on = 3'b000;
			end
		end
		high_n_next = ~hi_on;
		low_next    = lo_on;
	end

	// Core state registers.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			osc_cnt_reg        <= 16'h0000;
			tach_cnt_reg       <= 16'h0000;
			pwm_latch_reg      <= 1'b0;
			dir_latch_reg      <= 1'b0;
			dir_prev_reg       <= 1'b0;
			dir_shift_reg      <= 2'b00;
			pos_reg            <= 3'h0;
			tach_pulse         <= 1'b0;
			soft_start_node    <= 1'b1;
			high_side_drives_n <= 3'b111;
			low_side_drives    <= 3'b000;
		end
		else
		begin
			osc_cnt_reg        <= osc_cnt_next;
			tach_cnt_reg       <= tach_cnt_next;
			pwm_latch_reg      <= pwm_latch_next;
			dir_latch_reg      <= dir_latch_next;
			dir_prev_reg       <= dir_prev_next;
			dir_shift_reg      <= dir_shift_next;
			pos_reg            <= pos_next;
			tach_pulse         <= tach_next;
			soft_start_node    <= ss_next;
			high_side_drives_n <= high_n_next;
			low_side_drives    <= low_next;
		end
	end

	// Register file: control, sticky status cleared by read, mask, live state.
	logic [31:0] ctrl_reg, ctrl_next, mask_reg, mask_next, prdata_next;
	event_t status_reg, status_next, ev;
	logic pready_next, pslverr_next, irq_next, acc_done, oc_d_reg, ov_d_reg, uv_d_reg, dir_d_reg;
	logic mapped;

	assign enable   = ctrl_reg[`CTRL_ENABLE_BIT];
	assign acc_done = psel && penable && pready;
	assign mapped   = (paddr == `ADDR_CTRL) || (paddr == `ADDR_STATUS) ||
		(paddr == `ADDR_MASK) || (paddr == `ADDR_STATE);

	// Events are rising edges of faults, applied direction changes and commutations.
	always_comb
	begin
		ev = 5'h00;
		ev[`EV_OVER_CURRENT] = oc_s && !oc_d_reg;
		ev[`EV_OVERVOLTAGE]  = ov_s && !ov_d_reg;
		ev[`EV_DIR_APPLIED]  = dir_shift_reg[1] != dir_d_reg;
		ev[`EV_COMMUTATION]  = pos_load;
		ev[`EV_UNDERVOLTAGE] = uv_s && !uv_d_reg;
	end

	// Bus answers one cycle into the access phase; set wins over read-clear.
	always_comb
	begin
		ctrl_next    = ctrl_reg;
		mask_next    = mask_reg;
		status_next  = status_reg;
		pready_next  = psel && penable && !pready;
		pslverr_next = psel && penable && !pready && !mapped;
		prdata_next  = 32'h0000_0000;
		if (psel && penable && !pready && !pwrite)
		begin
			case (paddr)
				`ADDR_CTRL:   prdata_next = ctrl_reg;
				`ADDR_STATUS: prdata_next = {27'h0000000, status_reg};
				`ADDR_MASK:   prdata_next = mask_reg;
				`ADDR_STATE:  prdata_next = {22'h000000, soft_start_node, tach_pulse, brake_s,
					pwm_latch_reg, dir_inhibit, dir_latch_reg, dir_shift_reg[1], pos_reg};
				default:      prdata_next = 32'h0000_0000;
			endcase
		end
		if (acc_done && pwrite && (paddr == `ADDR_CTRL))
			ctrl_next = {31'h00000000, pwdata[0]};
		if (acc_done && pwrite && (paddr == `ADDR_MASK))
			mask_next = {27'h0000000, pwdata[4:0]};
		if (acc_done && !pwrite && (paddr == `ADDR_STATUS))
			status_next = 5'h00;
		status_next = status_next | ev;
		irq_next = |(status_reg & mask_reg[4:0]);
	end

	// Register file storage.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ctrl_reg   <= `CTRL_RESET;
			mask_reg   <= `MASK_RESET;
			status_reg <= 5'h00;
			prdata     <= 32'h0000_0000;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			irq        <= 1'b0;
			oc_d_reg   <= 1'b0;
			ov_d_reg   <= 1'b0;
			uv_d_reg   <= 1'b0;
			dir_d_reg  <= 1'b0;
		end
		else
		begin
			ctrl_reg   <= ctrl_next;
			mask_reg   <= mask_next;
			status_reg <= status_next;
			prdata     <= prdata_next;
			pready     <= pready_next;
			pslverr    <= pslverr_next;
			irq        <= irq_next;
			oc_d_reg   <= oc_s;
			ov_d_reg   <= ov_s;
			uv_d_reg   <= uv_s;
			dir_d_reg  <= dir_shift_reg[1];
		end
	end

	sequence s_all_off;
		(low_side_drives == 3'b000) && (high_side_drives_n == 3'b111);
	endsequence

	property p_dir_guard;
		@(posedge clock) disable iff (rst) (dir_inhibit && !brake_s) |=> s_all_off;
	endproperty
	a_dir_guard: assert property (p_dir_guard) else $error("Drives on during direction change.");

	property p_latch_hold;
		@(posedge clock) disable iff (rst) !speed_low_s |=> $stable(dir_latch_reg);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("Direction latch moved at speed.");

	property p_shift_tick;
		@(posedge clock) disable iff (rst) !osc_tick |=> $stable(dir_shift_reg);
	endproperty
	a_shift_tick: assert property (p_shift_tick) else $error("Direction register moved off tick.");

	property p_over_current;
		@(posedge clock) disable iff (rst) oc_s |=> s_all_off ##0 soft_start_node;
	endproperty
	a_over_current: assert property (p_over_current) else $error("Over-current left drives on.");

	property p_coast;
		@(posedge clock) disable iff (rst) ov_s |=> s_all_off;
	endproperty
	a_coast: assert property (p_coast) else $error("Coast left drives on.");

	property p_pwm_clear;
		@(posedge clock) disable iff (rst) (pwm_cmp_s && !osc_tick) |=> !pwm_latch_reg;
	endproperty
	a_pwm_clear: assert property (p_pwm_clear) else $error("PWM latch not cleared.");

	property p_tach_start;
		@(posedge clock) disable iff (rst) (pos_load && !brake_s) |=> tach_pulse ##1 tach_pulse;
	endproperty
	a_tach_start: assert property (p_tach_start) else $error("Commutation gave no tach pulse.");

	property p_tach_dir;
		@(posedge clock) disable iff (rst) (dir_s != dir_prev_reg) |=> tach_pulse;
	endproperty
	a_tach_dir: assert property (p_tach_dir) else $error("Direction toggle gave no tach pulse.");

	property p_pos_block;
		@(posedge clock) disable iff (rst) tach_pulse |=> $stable(pos_reg);
	endproperty
	a_pos_block: assert property (p_pos_block) else $error("Position moved during tach pulse.");

	property p_brake;
		@(posedge clock) disable iff (rst) brake_s |=> (high_side_drives_n == 3'b111);
	endproperty
	a_brake: assert property (p_brake) else $error("High side on while braking.");

	property p_bad_code;
		@(posedge clock) disable iff (rst) ((pos_reg == 3'h0) || (pos_reg == 3'h7)) && !brake_s |=> s_all_off;
	endproperty
	a_bad_code: assert property (p_bad_code) else $error("Invalid code drove outputs.");

	property p_sync;
		@(posedge clock) disable iff (rst) (!$past(rst) && !$past(rst, 2)) |->
			(pos_s == $past({rotor_sensor_a, rotor_sensor_b, rotor_sensor_c}, 2));
	endproperty
	a_sync: assert property (p_sync) else $error("Position sync depth wrong.");
endmodule
`default_nettype wire

// [bldc_defines.svh]
// Offsets, field positions, reset values and timing constants of the commutation block.
`ifndef BLDC_DEFINES_SVH
`define BLDC_DEFINES_SVH
`define CLK_MHZ           200
`define OSC_FREQ_KHZ      50
`define TACH_ON_US        220
`define OSC_CYCLES        ((`CLK_MHZ * 1000) / `OSC_FREQ_KHZ)
`define TACH_CYCLES       (`TACH_ON_US * `CLK_MHZ)
`define ADDR_CTRL         12'h000
`define ADDR_STATUS       12'h004
`define ADDR_MASK         12'h008
`define ADDR_STATE        12'h00c
`define CTRL_RESET        32'h0000_0001
`define MASK_RESET        32'h0000_0000
`define CTRL_ENABLE_BIT   0
`define EV_OVER_CURRENT   0
`define EV_OVERVOLTAGE    1
`define EV_DIR_APPLIED    2
`define EV_COMMUTATION    3
`define EV_UNDERVOLTAGE   4
`define EV_COUNT          5
`define SYNC_WIDTH        13
`endif

// [bldc_pkg.sv]
// Types shared by the commutation block.
package bldc_pkg;
	typedef logic [2:0] phase_t;
	typedef logic [4:0] event_t;
	typedef logic [15:0] count_t;
endpackage

// [bldc_sync.sv]
// Two-stage synchroniser for a vector of levels.
`timescale 1ns/10ps
`default_nettype none
module bldc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input  wire logic             clock,
	input  wire logic             rst,
	// Level in and synchronised level out.
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] out_next;

	// The first stage is read only by the second stage.
	always_comb
	begin
		meta_next = din;
		out_next  = meta_reg;
	end

	// Both stages register here.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			meta_reg <= '0;
			dout     <= '0;
		end
		else
		begin
			meta_reg <= meta_next;
			dout     <= out_next;
		end
	end
endmodule
`default_nettype wire

// [hall_stage_model.sv]
// Behavioural model of the rotor position sensors that feed the block.
`timescale 1ns/10ps
`default_nettype none
module hall_stage_model #(
	parameter bit SIXTY_DEG = 1'b0
) (
	// Clock and reset.
	input  wire logic       clock,
	input  wire logic       rst,
	// Step command and test override of the code.
	input  wire logic       step,
	input  wire logic       force_en,
	input  wire logic [2:0] force_code,
	// Sensor levels.
	output logic            rotor_sensor_a,
	output logic            rotor_sensor_b,
	output logic            rotor_sensor_c
);
	localparam logic [2:0] SEQ [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
	localparam logic [2:0] FLIP    = SIXTY_DEG ? 3'h2 : 3'h0;
	logic [2:0] idx;
	logic [2:0] raw;
	always_ff @(posedge clock or posedge rst)
		if (rst)
			idx <= 3'h0;
		else if (step)
			idx <= (idx == 3'h5) ? 3'h0 : idx + 3'h1;
	assign raw = SEQ[idx] ^ FLIP;
	assign {rotor_sensor_a, rotor_sensor_b, rotor_sensor_c} = force_en ? force_code : raw ^ FLIP;
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking testbench of the commutation and direction block.
`timescale 1ns/10ps
`default_nettype none
`include "bldc_defines.svh"
module tb;
	import bldc_pkg::*;
	localparam int OSC = 20;
	localparam int TACH = 8;
	localparam logic [2:0] SEQ [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
	logic        clock, rst, psel, penable, pwrite, pready, pslverr, irq, tach_pulse, soft_start_node, step, er, seen;
	logic        rotor_sensor_a, rotor_sensor_b, rotor_sensor_c, dir_request, speed_below_threshold, quad_select;
	logic        pwm_comparator_flag, peak_current_flag, over_current_flag, overvoltage_coast_input;
	logic        brake_timing_input, undervoltage_flag, soft_start_discharged, force_en;
	logic [2:0]  force_code, high_side_drives_n, low_side_drives;
	logic [5:0]  e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int          bad_count, comparisons, idx, tach_len;
	int          cycles = 0;
	bldc_commutation_direction_ctrl #(.OSC_CYCLES(OSC), .TACH_CYCLES(TACH)) u_bldc_commutation_direction_ctrl (.clock,
		.rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rotor_sensor_a, .rotor_sensor_b,
		.rotor_sensor_c, .dir_request, .speed_below_threshold, .pwm_comparator_flag, .peak_current_flag,
		.over_current_flag, .overvoltage_coast_input, .brake_timing_input, .quad_select, .undervoltage_flag,
		.soft_start_discharged, .high_side_drives_n, .low_side_drives, .tach_pulse, .soft_start_node, .irq);
	hall_stage_model u_hall_stage_model (.clock, .rst, .step, .force_en, .force_code, .rotor_sensor_a,
		.rotor_sensor_b, .rotor_sensor_c);
	// Clock at 200 MHz.
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Prints the counts and the verdict, then stops.
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Cuts a hang short.
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			bad_count++;
			complete_run();
		end
	end
	// Compares a value and counts the outcome.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Expected active-low high sides and low sides for a sensor code.
	function automatic logic [5:0] drv(input logic [2:0] c, input logic rev);
		logic [5:0] hl;
		case (c)
			3'h5: hl = 6'h22;
			3'h4: hl = 6'h21;
			3'h6: hl = 6'h11;
			3'h2: hl = 6'h14;
			3'h3: hl = 6'h0c;
			3'h1: hl = 6'h0a;
			default: hl = 6'h00;
		endcase
		return rev ? {~hl[2:0], hl[5:3]} : {~hl[5:3], hl[2:0]};
	endfunction
	task automatic cdrv(input logic [5:0] exp);
		check({26'h0, high_side_drives_n, low_side_drives}, {26'h0, exp});
	endtask
	// One APB transfer, waiting for pready.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clock);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
		@(posedge clock);
		penable <= 1'b1;
		// Ends when pready is seen; only the bench timeout ends it if pready never comes.
		do
			@(posedge clock);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	// Advances the rotor by one step.
	task automatic adv;
		step <= 1'b1;
		idx = (idx + 1) % 6;
		tick(1);
		step <= 1'b0;
	endtask
	// Watches the tach output for a number of cycles.
	task automatic watch_tach(input int n);
		tach_len = 0;
		repeat (n)
		begin
			tick(1);
			tach_len += int'(tach_pulse === 1'b1);
		end
		seen = (tach_len != 0);
	endtask
	// Register defaults, refused address and the commutation interrupt.
	task automatic t_regs;
		apb(0, `ADDR_CTRL, 0);
		check(rd, `CTRL_RESET);
		check(er, 32'h0);
		apb(0, `ADDR_MASK, 0);
		check(rd, `MASK_RESET);
		apb(1, 12'h010, 32'h1f);
		check(er, 32'h1);
		apb(0, 12'h010, 0);
		check(er, 32'h1);
		check(rd, 32'h0);
		apb(0, `ADDR_STATUS, 0);
		apb(1, `ADDR_MASK, 32'h1 << `EV_COMMUTATION);
		adv();
		tick(30);
		check(irq, 32'h1);
		apb(0, `ADDR_STATUS, 0);
		check(rd[`EV_COMMUTATION], 32'h1);
		tick(4);
		check(irq, 32'h0);
		apb(1, `ADDR_MASK, 0);
		// Clearing the enable bit turns every drive off until it is set again.
		apb(1, `ADDR_CTRL, 0);
		tick(4);
		cdrv(drv(3'h0, 1'b0));
		apb(0, `ADDR_CTRL, 0);
		check(rd, 32'h0);
		apb(1, `ADDR_CTRL, 1);
		tick(4);
		cdrv(drv(SEQ[idx], 1'b0));
	endtask
	// Full forward table, invalid codes, and position changes during tach.
	task automatic t_table;
		for (int i = 0; i < 6; i++)
		begin
			adv();
			tick(30);
			cdrv(drv(SEQ[idx], 1'b0));
		end
		e = drv(SEQ[idx], 1'b0);
		adv();
		tick(2);
		adv();
		tick(4);
		cdrv(drv(SEQ[(idx + 5) % 6], 1'b0));
		tick(30);
		cdrv(drv(SEQ[idx], 1'b0));
		for (int c = 0; c < 2; c++)
		begin
			force_code <= c ? 3'h7 : 3'h0;
			force_en <= 1'b1;
			tick(30);
			cdrv(drv(3'h0, 1'b0));
		end
		force_en <= 1'b0;
		tick(30);
	endtask
	// Reversal while slow, then a refused reversal while fast.
	task automatic t_dir;
		speed_below_threshold <= 1'b1;
		dir_request <= 1'b1;
		watch_tach(OSC);
		check(seen, 32'h1);
		check(tach_len, TACH);
		cdrv(drv(3'h0, 1'b0));
		tick(2 * OSC + 20);
		cdrv(drv(SEQ[idx], 1'b1));
		dir_request <= 1'b0;
		tick(3 * OSC);
		cdrv(drv(SEQ[idx], 1'b0));
		speed_below_threshold <= 1'b0;
		dir_request <= 1'b1;
		tick(3 * OSC);
		cdrv(drv(3'h0, 1'b0));
		apb(0, `ADDR_STATE, 0);
		check(rd[4:3], 32'h0);
		dir_request <= 1'b0;
		speed_below_threshold <= 1'b1;
		tick(3 * OSC);
	endtask
	// Over-current, overvoltage and undervoltage each turn drives off.
	task automatic t_faults;
		for (int k = 0; k < 3; k++)
		begin
			{over_current_flag, overvoltage_coast_input, undervoltage_flag} <= 3'h4 >> k;
			tick(10);
			cdrv(drv(3'h0, 1'b0));
			if (k == 0)
				check(soft_start_node, 32'h1);
			{over_current_flag, overvoltage_coast_input, undervoltage_flag} <= 3'h0;
			tick(3 * OSC);
			cdrv(drv(SEQ[idx], 1'b0));
		end
	endtask
	// Chopping in both quadrant modes, peak limit, and brake.
	task automatic t_chop;
		e = drv(SEQ[idx], 1'b0);
		pwm_comparator_flag <= 1'b1;
		tick(10);
		cdrv({e[5:3], 3'h0});
		quad_select <= 1'b1;
		tick(10);
		cdrv(drv(3'h0, 1'b0));
		{quad_select, pwm_comparator_flag, peak_current_flag} <= 3'h1;
		tick(OSC + 10);
		cdrv({e[5:3], 3'h0});
		{peak_current_flag, brake_timing_input} <= 2'h1;
		tick(OSC + 10);
		cdrv(6'h3f);
		adv();
		watch_tach(12);
		check(seen, 32'h0);
		{quad_select, pwm_comparator_flag} <= 2'h1;
		tick(10);
		cdrv(6'h38);
		{quad_select, pwm_comparator_flag, brake_timing_input} <= 3'h0;
		tick(2 * OSC);
		cdrv(drv(SEQ[idx], 1'b0));
	endtask
	// Main sequence.
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, step, force_en, force_code} = '0;
		{dir_request, speed_below_threshold, quad_select, pwm_comparator_flag, peak_current_flag} = '0;
		{over_current_flag, overvoltage_coast_input, brake_timing_input, undervoltage_flag} = '0;
		{soft_start_discharged, bad_count, comparisons, idx} = '0;
		rst = 1'b1;
		tick(12);
		cdrv(drv(3'h0, 1'b0));
		rst <= 1'b0;
		tick(20);
		check(soft_start_node, 32'h1);
		soft_start_discharged <= 1'b1;
		tick(3 * OSC);
		cdrv(drv(SEQ[0], 1'b0));
		t_regs();
		t_table();
		t_dir();
		t_faults();
		t_chop();
		complete_run();
	end
endmodule
`default_nettype wire
